// ---- shared/crp_pkg.sv ----
// Package of constants and types for the code region profiler counter.
package crp_pkg;
  // ******************************************************************
  // Geometry
  // ******************************************************************
  localparam int          NUM_REGIONS = 3;
  localparam int          ADDR_W      = 32;
  localparam int          CNT_W       = 32;
  localparam int          DIV_W       = 3;
  localparam int          PRESC_W     = 5;
  localparam logic [2:0]  DIV_MAX     = 3'h5;
  // ******************************************************************
  // Register map, byte addresses
  // ******************************************************************
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_REGION  = 8'h10;
  localparam logic [7:0]  REGION_STEP = 8'h20;
  localparam logic [7:0]  OFF_ENTRY   = 8'h00;
  localparam logic [7:0]  OFF_EXIT    = 8'h04;
  localparam logic [7:0]  OFF_CFG     = 8'h08;
  localparam logic [7:0]  OFF_VALUE   = 8'h0c;
  localparam logic [7:0]  OFF_TALLY   = 8'h10;
  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int          CTRL_START_BIT   = 0;
  localparam int          CTRL_STOP_BIT    = 1;
  localparam int          CTRL_AUTO_BIT    = 2;
  localparam int          CTRL_RESTART_BIT = 3;
  localparam int          CFG_SRC_BIT      = 0;
  localparam int          CFG_DIV_LSB      = 4;
  localparam int          STATUS_RUN_BIT   = 0;
  localparam int          STATUS_VALID_BIT = 1;
  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 32'h0000_0000;
  typedef enum logic {CRP_SRC_CYCLES = 1'b0, CRP_SRC_INSNS = 1'b1} crp_src_t;
  typedef enum logic [1:0] {
    CRP_IDLE = 2'b00,
    CRP_RUN  = 2'b01,
    CRP_DONE = 2'b10
  } crp_state_t;
endpackage

// ---- shared/crp_region_if.sv ----
// Interface between the profiler control and one region counter.
`timescale 1ns/1ps
interface crp_region_if;
  import crp_pkg::*;
  logic [ADDR_W-1:0] entryAddr;
  logic [ADDR_W-1:0] exitAddr;
  crp_src_t          countSrc;
  logic [DIV_W-1:0]  divSel;
  logic              clear;
  logic              counting;
  logic [CNT_W-1:0]  value;
  logic [CNT_W-1:0]  tally;
  modport ctrl (output entryAddr, exitAddr, countSrc, divSel, clear, counting,
                input value, tally);
  modport region (input entryAddr, exitAddr, countSrc, divSel, clear, counting,
                  output value, tally);
endinterface

// ---- rtl/crp_region.sv ----
// One code region: inside tracking, divided cycle or instruction count, entry tally.
`timescale 1ns/1ps
module crp_region
  import crp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              insnValid,
  input  wire logic [ADDR_W-1:0] insnAddr,
  crp_region_if.region           rif
);
  logic               inside_q;
  logic [PRESC_W-1:0] presc_q;
  logic [CNT_W-1:0]   value_q;
  logic [CNT_W-1:0]   tally_q;
  wire  hitEntry = insnValid && (insnAddr == rif.entryAddr);
  wire  hitExit  = insnValid && (insnAddr == rif.exitAddr);
  // The exit instruction itself is still counted as time inside the region.
  wire  active   = rif.counting && (inside_q || hitEntry);
  wire  [PRESC_W-1:0] divMask = PRESC_W'((1 << rif.divSel) - 1);
  wire  divTick  = (presc_q & divMask) == divMask;
  wire  cycleInc = active && divTick; // RULE3
  wire  insnInc  = active && insnValid;
  wire  doInc    = (rif.countSrc == CRP_SRC_INSNS) ? insnInc : cycleInc; // RULE2
  assign rif.value = value_q;
  assign rif.tally = tally_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inside_q <= 1'b0;
      presc_q  <= '0;
      value_q  <= CNT_RST;
      tally_q  <= CNT_RST;
    end else if (rif.clear) begin
      inside_q <= 1'b0; // RULE10
      presc_q  <= '0;
      value_q  <= CNT_RST;
      tally_q  <= CNT_RST;
    end else if (rif.counting) begin
      inside_q <= hitExit ? 1'b0 : (hitEntry ? 1'b1 : inside_q); // RULE4
      presc_q  <= active ? presc_q + PRESC_W'(1) : presc_q;
      value_q  <= doInc ? value_q + CNT_W'(1) : value_q; // RULE4
      tally_q  <= (hitEntry && !inside_q) ? tally_q + CNT_W'(1) : tally_q; // RULE5
    end
  end
endmodule

// ---- rtl/crp_profiler.sv ----
// Top of the code region profiler counter: APB registers, run control, three regions.
// Operation
// RULE1 - Three regions, each with entry and exit
// RULE2 - Per region choose cycles or instructions
// RULE3 - Cycle count divided by 1 to 32
// RULE4 - Count only between entry and exit
// RULE5 - Tally each entry into region
// RULE6 - Results valid only after profiler stopped
// RULE7 - Auto-start when CPU leaves reset
// RULE8 - Debugger restarts before each run/step; the RESTART bit of CTRL is only stored and read back, nothing restarts
// RULE9 - Entry and exit three instructions apart
// RULE10 - Start clears all counters and tallies
`timescale 1ns/1ps
module crp_profiler
  import crp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cpuResetN,
  input  wire logic              insnValid,
  input  wire logic [ADDR_W-1:0] insnAddr,
  output logic                   running
);
  // ******************************************************************
  // Bus decode
  // ******************************************************************
  crp_state_t        state_q;
  crp_state_t        state_d;
  logic              autoStart_q;
  logic              restartOpt_q;
  logic              cpuResetN_q;
  logic [ADDR_W-1:0] entry_q [NUM_REGIONS];
  logic [ADDR_W-1:0] exit_q  [NUM_REGIONS];
  logic              src_q   [NUM_REGIONS];
  logic [DIV_W-1:0]  div_q   [NUM_REGIONS];
  logic [31:0]       rdata_q;
  logic [31:0]       regionWord;
  wire  access    = psel && penable;
  wire  wrEn      = access && pwrite;
  wire  rdEn      = access && !pwrite;
  wire  isCtrl    = paddr == OFF_CTRL;
  wire  isStatus  = paddr == OFF_STATUS;
  wire  [7:0] rel = paddr - OFF_REGION;
  // The full index is compared, so addresses past the last region do not alias onto region 0.
  wire  [7:0] relIdx = rel / REGION_STEP;
  wire  [1:0] regIdx = relIdx[1:0];
  wire  [7:0] regOff = rel % REGION_STEP;
  wire  inRegion  = (paddr >= OFF_REGION) && (32'(relIdx) < NUM_REGIONS) &&
                    (regOff <= OFF_TALLY) && (regOff[1:0] == 2'h0);
  wire  mapped    = isCtrl || isStatus || inRegion;
  wire  startCmd  = wrEn && isCtrl && pwdata[CTRL_START_BIT];
  wire  stopCmd   = wrEn && isCtrl && pwdata[CTRL_STOP_BIT];
  // The CPU leaving reset is a rising edge of its reset line, sampled once.
  wire  cpuRelease = cpuResetN && !cpuResetN_q;
  wire  autoGo    = autoStart_q && cpuRelease; // RULE7
  wire  goCmd     = startCmd || autoGo;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = rdata_q;
  assign running = state_q == CRP_RUN;
  // ******************************************************************
  // Run control
  // ******************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      CRP_IDLE: begin
        if (goCmd) state_d = CRP_RUN;
      end
      CRP_RUN: begin
        if (stopCmd && !startCmd) state_d = CRP_DONE;
      end
      CRP_DONE: begin
        if (goCmd) state_d = CRP_RUN;
      end
      default: state_d = CRP_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= CRP_IDLE;
      autoStart_q  <= 1'b0;
      restartOpt_q <= 1'b0;
      // Reset to the idle level of the line, so that no false release follows reset.
      cpuResetN_q  <= 1'b1;
    end else begin
      state_q     <= state_d;
      cpuResetN_q <= cpuResetN;
      if (wrEn && isCtrl) begin
        autoStart_q  <= pwdata[CTRL_AUTO_BIT];
        restartOpt_q <= pwdata[CTRL_RESTART_BIT];
      end
    end
  end
  // ******************************************************************
  // Region configuration and counters
  // ******************************************************************
  crp_region_if rif [NUM_REGIONS] ();
  logic [CNT_W-1:0] valueArr [NUM_REGIONS];
  logic [CNT_W-1:0] tallyArr [NUM_REGIONS];
  for (genvar g = 0; g < NUM_REGIONS; g++) begin : gReg // RULE1
    wire  cfgWr = wrEn && inRegion && (32'(regIdx) == g);
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        entry_q[g] <= ADDR_RST;
        exit_q[g]  <= ADDR_RST;
        src_q[g]   <= 1'b0;
        div_q[g]   <= '0;
      end else if (cfgWr && regOff == OFF_ENTRY) begin
        entry_q[g] <= pwdata;
      end else if (cfgWr && regOff == OFF_EXIT) begin
        exit_q[g]  <= pwdata;
      end else if (cfgWr && regOff == OFF_CFG) begin
        src_q[g]   <= pwdata[CFG_SRC_BIT]; // RULE2
        div_q[g]   <= (pwdata[CFG_DIV_LSB +: DIV_W] > DIV_MAX) ? DIV_MAX
                      : pwdata[CFG_DIV_LSB +: DIV_W]; // RULE3
      end
    end
    // Entry and exit closer than three instructions may miss an edge.
    assign rif[g].entryAddr = entry_q[g]; // RULE9
    assign rif[g].exitAddr  = exit_q[g];
    assign rif[g].countSrc  = crp_src_t'(src_q[g]);
    assign rif[g].divSel    = div_q[g];
    assign rif[g].clear     = goCmd; // RULE10
    assign rif[g].counting  = running;
    assign valueArr[g]      = rif[g].value;
    assign tallyArr[g]      = rif[g].tally;
    crp_region crp_region_inst (
      .clk       (clk),
      .reset_n   (reset_n),
      .insnValid (insnValid),
      .insnAddr  (insnAddr),
      .rif       (rif[g])
    );
  end
  // ******************************************************************
  // Read path
  // ******************************************************************
  // Counters keep moving while running, so reads then are only a snapshot.
  wire  resultsValid = state_q == CRP_DONE; // RULE6
  wire  [1:0] ri = (32'(regIdx) < NUM_REGIONS) ? regIdx : 2'h0;
  always_comb begin
    case (regOff)
      OFF_ENTRY: regionWord = entry_q[ri];
      OFF_EXIT:  regionWord = exit_q[ri];
      OFF_CFG:   regionWord = {{(32-CFG_DIV_LSB-DIV_W){1'b0}}, div_q[ri], 3'h0, src_q[ri]};
      OFF_VALUE: regionWord = valueArr[ri];
      OFF_TALLY: regionWord = tallyArr[ri];
      default:   regionWord = 32'h0000_0000;
    endcase
  end
  wire  [31:0] ctrlWord = {28'h0000000, restartOpt_q, autoStart_q, 2'h0};
  wire  [31:0] statWord = {30'h00000000, resultsValid, running};
  wire  [31:0] rdMux = isCtrl ? ctrlWord : isStatus ? statWord :
                       inRegion ? regionWord : 32'h0000_0000;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rdMux;
    end
  end
  wire  unusedRd = rdEn;
endmodule

// ---- dv/crp_cpu_model.sv ----
// Behavioural CPU core that replays a short looping program at the profiler.
`timescale 1ns/1ps
module crp_cpu_model
  import crp_pkg::*;
(
  input  wire logic              clk,
  output logic                   cpuResetN,
  output logic                   insnValid,
  output logic [ADDR_W-1:0]      insnAddr
);
  initial begin
    cpuResetN = 1'b1;
    insnValid = 1'b0;
    insnAddr  = 32'hffff_ffff;
  end
  task automatic hold_reset;
    @(posedge clk);
    cpuResetN <= 1'b0;
    repeat (3) @(posedge clk);
    cpuResetN <= 1'b1;
  endtask
  // Fifteen idle cycles after each instruction put instructions sixteen cycles apart.
  task automatic run(input int passes);
    for (int p = 0; p < passes; p++) begin
      for (int i = 0; i < 7; i++) begin
        @(posedge clk);
        insnValid <= 1'b1;
        insnAddr  <= 32'h0000_00fc + 32'(4 * i);
        repeat (15) begin
          @(posedge clk);
          insnValid <= 1'b0;
          insnAddr  <= ~insnAddr;
        end
      end
    end
  endtask
endmodule

// ---- dv/crp_profiler_checker.sv ----
// Assertions on the profiler's register bus and run state.
`timescale 1ns/1ps
module crp_profiler_checker
  import crp_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              cpuResetN,
  input wire logic              insnValid,
  input wire logic [ADDR_W-1:0] insnAddr,
  input wire logic              running
);
  logic autoStart_q;
  wire  ctrlWr = psel && penable && pwrite && paddr == OFF_CTRL;
  wire  rdAcc  = psel && penable && !pwrite;
  // Auto start is armed by the last CTRL write, so the bit is mirrored here.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      autoStart_q <= 1'b0;
    end else if (ctrlWr) begin
      autoStart_q <= pwdata[CTRL_AUTO_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr == 8'h08 |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr == OFF_STATUS |-> !pslverr)
    else $error("mapped access refused");
  a_start_runs: assert property (ctrlWr && pwdata[0] |=> running)
    else $error("start did not run");
  a_stop_halts: assert property (ctrlWr && pwdata[1] && !pwdata[0] |=> !running)
    else $error("stop did not halt");
  a_run_holds: assert property (running && !(ctrlWr && pwdata[1]) |=> running)
    else $error("run dropped");
  a_idle_holds: assert property (!running && !autoStart_q && !(ctrlWr && pwdata[0])
    |=> !running) else $error("run began uncommanded");
  a_auto_start: assert property (autoStart_q && $rose(cpuResetN) |-> ##[1:3] running)
    else $error("auto start missing");
  a_status_run: assert property (rdAcc && paddr == OFF_STATUS |->
    prdata[0] == $past(running)) else $error("status run bit wrong");
  c_start: cover property (ctrlWr && pwdata[0]);
  c_auto: cover property (autoStart_q && $rose(cpuResetN));
  c_refused: cover property (psel && penable && pslverr);
endmodule
bind crp_profiler crp_profiler_checker crp_profiler_checker_inst (.clk(clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpuResetN(cpuResetN), .insnValid(insnValid), .insnAddr(insnAddr), .running(running));

// ---- dv/test_crp_profiler.sv ----
// Self-checking bench for the code region profiler counter.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end
module test_crp_profiler;
  import crp_pkg::*;
  logic              clk, reset_n, psel, penable, pwrite, pready, pslverr, running;
  logic              cpuResetN, insnValid;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, lfsr, expV;
  logic [ADDR_W-1:0] insnAddr;
  logic [31:0]       expQ[$];
  int                fail_count, total_checks, p;
  // Three instructions sixteen cycles apart, plus the exit cycle, which still counts.
  localparam int     SPAN = 49;
  crp_profiler crp_profiler_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpuResetN(cpuResetN), .insnValid(insnValid),
    .insnAddr(insnAddr), .running(running));
  crp_cpu_model crp_cpu_model_inst (.clk(clk), .cpuResetN(cpuResetN),
    .insnValid(insnValid), .insnAddr(insnAddr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] base(input int n);
    return OFF_REGION + REGION_STEP * 8'(n);
  endfunction
  // Each transfer starts one edge after the last release, so no signal is set twice.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic stop_test;
    if (expQ.size() != 0) fail_count++;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ******************************************************************
  // Read monitor
  // ******************************************************************
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready && expQ.size() > 0) begin
      expV = expQ.pop_front();
      `CHK("read data", expV, prdata)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test;
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    lfsr = 32'h2d3b;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(OFF_STATUS, 32'h0);
    rd(8'h08, 32'h0);
    for (int d = 0; d < 6; d++) begin
      lfsr = nxt(lfsr);
      p = 1 + int'(lfsr[1:0]);
      for (int n = 0; n < 3; n++) begin
        wr(base(n) + OFF_ENTRY, 32'h100 + 32'(4 * n));
        wr(base(n) + OFF_EXIT, 32'h10c + 32'(4 * n));
      end
      wr(base(0) + OFF_CFG, {25'h0, lfsr[6:4], 4'h1});
      wr(base(1) + OFF_CFG, 32'(d) << CFG_DIV_LSB);
      wr(base(2) + OFF_CFG, 32'h70);
      wr(OFF_CTRL, 32'h1);
      crp_cpu_model_inst.run(p);
      wr(OFF_CTRL, 32'h2);
      rd(OFF_STATUS, 32'h2);
      rd(base(0) + OFF_VALUE, 32'(4 * p));
      rd(base(1) + OFF_VALUE, 32'((SPAN * p) >> d));
      rd(base(2) + OFF_VALUE, 32'((SPAN * p) >> DIV_MAX));
      for (int n = 0; n < 3; n++) rd(base(n) + OFF_TALLY, 32'(p));
    end
    wr(OFF_CTRL, 32'h4);
    crp_cpu_model_inst.hold_reset();
    repeat (4) @(posedge clk);
    rd(OFF_STATUS, 32'h1);
    crp_cpu_model_inst.run(1);
    wr(OFF_CTRL, 32'h2);
    rd(base(0) + OFF_VALUE, 32'h4);
    @(posedge clk);
    stop_test;
  end
endmodule
